// file: src/vbsc_consts.vh
`ifndef VBSC_CONSTS_VH
`define VBSC_CONSTS_VH
// ----------------------------------------
// Command codes
// ----------------------------------------
`define VBSC_CMD_SRC_DEF     8'h77
`define VBSC_CMD_SRC_NDEF    8'h88
`define VBSC_CMD_DISABLE     8'h66
// ----------------------------------------
// Reset values of settings
// ----------------------------------------
`define VBSC_SLOPE_RST       3'h0
`define VBSC_FREQ_RST        2'h2
`define VBSC_SPREAD_RST      2'h0
`define VBSC_SYNC_DIR_RST    1'h1
`define VBSC_WIN_THR_RST     2'h0
`define VBSC_ILIM_RST        8'h00
`define VBSC_TARGET_RST      12'h000
// ----------------------------------------
// Timing
// ----------------------------------------
`define VBSC_CLK_KHZ         100000
`define VBSC_SOFT_START_US   6500
`define VBSC_SOFT_START_CYC  ((`VBSC_SOFT_START_US * `VBSC_CLK_KHZ) / 1000)
`endif

// file: src/vbsc_ctrl.v
// Contract
// - Set under flag when LDO below 2.7V
// - Set over flag when LDO above 4.0V
// - Slope field selects 100..800mV ramp
// - Frequency field picks one of four
// - Spread field picks 3/6/9 percent dither
// - SYNC defaults to input after power-up
// - Window thresholds default 12.5 percent
// - Error when enabling while not discharged
// - 0x77 soft-starts to default 5.15V
// - 0x88 moves to custom target
// - Current limit accepted while sourcing
// - 0x66 turns converter off
// - Soft-start ramp takes 6.5ms
// - Power-up done when alert follows enable
`include "vbsc_consts.vh"
module vbsc_ctrl #(
	parameter SS_CYC = `VBSC_SOFT_START_CYC, // Soft-start length
	parameter TW     = 12                    // Target width
) (
	input  wire          core_clk,
	input  wire          nrst,
	input  wire          hv_enable_in,
	input  wire          ldo_below_cmp,
	input  wire          ldo_above_cmp,
	input  wire          output_discharged_in,
	input  wire          cmd_wr,
	input  wire [7:0]    cmd_code,
	input  wire          cfg_wr,
	input  wire [2:0]    slope_in,
	input  wire [1:0]    freq_in,
	input  wire [1:0]    spread_in,
	input  wire          sync_dir_in,
	input  wire [1:0]    win_thr_in,
	input  wire          ilim_wr,
	input  wire [7:0]    ilim_in,
	input  wire          target_wr,
	input  wire [TW-1:0] target_in,
	input  wire          flag_clr,
	output reg           alert_n,
	output reg           ldo3v3_under_flag,
	output reg           ldo3v3_over_flag,
	output reg           i2c_err_flag,
	output reg           output_discharged_flag,
	output reg  [2:0]    slope_ramp_sel,
	output reg  [1:0]    switch_freq_sel,
	output reg  [1:0]    spread_sel,
	output reg           sync_dir,
	output reg  [1:0]    bus_window_thresholds,
	output reg  [7:0]    ilim_sel,
	output reg  [TW-1:0] custom_voltage_target,
	output reg           conv_on,
	output reg           use_custom,
	output reg           ramping,
	output reg  [3:0]    state_out
);
	// ----------------------------------------
	// States
	// ----------------------------------------
	localparam ST_OFF  = 4'b0001; // Converter off
	localparam ST_RAMP = 4'b0010; // Soft-start ramp
	localparam ST_DEF  = 4'b0100; // At default voltage
	localparam ST_CUST = 4'b1000; // At custom voltage

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	wire [3:0] sync_q; // Synchronised pin inputs
	vbsc_sync2 #(.W(4)) u_sync (
		.core_clk (core_clk),
		.nrst     (nrst),
		.d        ({hv_enable_in, ldo_below_cmp,
		            ldo_above_cmp, output_discharged_in}),
		.q        (sync_q)
	);
	wire hv_s    = sync_q[3]; // Enable level
	wire below_s = sync_q[2]; // LDO under comparator
	wire above_s = sync_q[1]; // LDO over comparator
	wire disch_s = sync_q[0]; // Output at safe zero

	reg  [3:0]  state_reg;   // Source state
	reg  [3:0]  state_next;  // Next source state
	reg  [31:0] ramp_reg;    // Soft-start counter
	reg         err_set;     // Error event this cycle
	reg         pwr_done_reg; // Power-up finished

	// ----------------------------------------
	// Power-up tracking and status flags
	// ----------------------------------------
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			pwr_done_reg           <= 1'b0;
			alert_n                <= 1'b1;
			ldo3v3_under_flag      <= 1'b0;
			ldo3v3_over_flag       <= 1'b0;
			i2c_err_flag           <= 1'b0;
			output_discharged_flag <= 1'b0;
		end else begin
			// Done once enable seen high; low drops back
			pwr_done_reg <= hv_s;
			alert_n      <= ~hv_s;
			output_discharged_flag <= disch_s;
			// Set wins over clear
			if (below_s)
				ldo3v3_under_flag <= 1'b1;
			else if (flag_clr)
				ldo3v3_under_flag <= 1'b0;
			if (above_s)
				ldo3v3_over_flag <= 1'b1;
			else if (flag_clr)
				ldo3v3_over_flag <= 1'b0;
			if (err_set)
				i2c_err_flag <= 1'b1;
			else if (flag_clr)
				i2c_err_flag <= 1'b0;
		end
	end

	// ----------------------------------------
	// Configuration settings
	// ----------------------------------------
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			slope_ramp_sel        <= `VBSC_SLOPE_RST;
			switch_freq_sel       <= `VBSC_FREQ_RST;
			spread_sel            <= `VBSC_SPREAD_RST;
			sync_dir              <= `VBSC_SYNC_DIR_RST;
			bus_window_thresholds <= `VBSC_WIN_THR_RST;
			ilim_sel              <= `VBSC_ILIM_RST;
			custom_voltage_target <= `VBSC_TARGET_RST;
		end else begin
			if (cfg_wr && pwr_done_reg) begin
				slope_ramp_sel        <= slope_in;
				switch_freq_sel       <= freq_in;
				spread_sel            <= spread_in;
				sync_dir              <= sync_dir_in;
				bus_window_thresholds <= win_thr_in;
			end
			// Any state, including while sourcing
			if (ilim_wr && pwr_done_reg)
				ilim_sel <= ilim_in;
			if (target_wr && pwr_done_reg)
				custom_voltage_target <= target_in;
		end
	end

	// ----------------------------------------
	// Command decode and next state
	// ----------------------------------------
	always @* begin
		state_next = state_reg;
		err_set    = 1'b0;
		if (cmd_wr && pwr_done_reg) begin
			if (cmd_code == `VBSC_CMD_DISABLE) begin
				state_next = ST_OFF;
			end else if (cmd_code == `VBSC_CMD_SRC_DEF) begin
				case (state_reg)
					ST_OFF: begin
						// Decide on the reported discharged status
						if (output_discharged_flag)
							state_next = ST_RAMP;
						else
							err_set = 1'b1;
					end
					ST_CUST: begin
						state_next = ST_DEF;
					end
					default: begin
						state_next = state_reg;
					end
				endcase
			end else if (cmd_code == `VBSC_CMD_SRC_NDEF) begin
				case (state_reg)
					ST_DEF:  state_next = ST_CUST;
					ST_CUST: state_next = ST_CUST;
					default: err_set = 1'b1;
				endcase
			end
		end
		// Soft-start end
		if (state_reg == ST_RAMP && state_next == ST_RAMP &&
		    ramp_reg >= SS_CYC - 1)
			state_next = ST_DEF;
		// Losing enable forces off
		if (!pwr_done_reg)
			state_next = ST_OFF;
	end

	// ----------------------------------------
	// State register and outputs
	// ----------------------------------------
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			state_reg  <= ST_OFF;
			ramp_reg   <= 32'h00000000;
			conv_on    <= 1'b0;
			use_custom <= 1'b0;
			ramping    <= 1'b0;
			state_out  <= ST_OFF;
		end else begin
			state_reg <= state_next;
			// Count only while ramping
			if (state_next == ST_RAMP && state_reg == ST_RAMP)
				ramp_reg <= ramp_reg + 32'h00000001;
			else
				ramp_reg <= 32'h00000000;
			conv_on    <= (state_next != ST_OFF);
			use_custom <= (state_next == ST_CUST);
			ramping    <= (state_next == ST_RAMP);
			state_out  <= state_next;
		end
	end
endmodule // vbsc_ctrl

// file: src/vbsc_sync2.v
// ----------------------------------------
// Two-flop synchroniser, one per bit
// ----------------------------------------
module vbsc_sync2 #(
	parameter W = 1
) (
	input  wire         core_clk,
	input  wire         nrst,
	input  wire [W-1:0] d,
	output wire [W-1:0] q
);
	reg [W-1:0] s1_reg; // First stage, read only by second
	reg [W-1:0] s2_reg; // Second stage
	genvar i;
	generate
		for (i = 0; i < W; i = i + 1) begin : g_bit
			// Per-bit double flop
			always @(posedge core_clk or negedge nrst) begin
				if (!nrst) begin
					s1_reg[i] <= 1'b0;
					s2_reg[i] <= 1'b0;
				end else begin
					s1_reg[i] <= d[i];
					s2_reg[i] <= s1_reg[i];
				end
			end
		end
	endgenerate
	assign q = s2_reg;
endmodule // vbsc_sync2

// file: tb/test_vbus_source_command_control.sv
module test_vbus_source_command_control;
	timeunit 1ns;
	timeprecision 1ps;
	localparam SS = 20;
	logic        core_clk, nrst, hv_enable_in, ldo_below_cmp, ldo_above_cmp;
	logic        output_discharged_in, flag_clr;
	int          errors = 0, cmp_count = 0, i;
	wire  [3:0]  stb, state_out;
	wire  [11:0] dat, custom_voltage_target;
	wire         alert_n, ldo3v3_under_flag, ldo3v3_over_flag, i2c_err_flag;
	wire         output_discharged_flag, sync_dir, conv_on, use_custom, ramping;
	wire  [2:0]  slope_ramp_sel;
	wire  [1:0]  switch_freq_sel, spread_sel, bus_window_thresholds;
	wire  [7:0]  ilim_sel;
	vbsc_ctrl #(.SS_CYC(SS)) i_vbsc_ctrl (.*, .cfg_wr(stb[0]),
		.ilim_wr(stb[1]), .target_wr(stb[2]), .cmd_wr(stb[3]),
		.cmd_code(dat[7:0]), .slope_in(dat[2:0]), .freq_in(dat[4:3]),
		.spread_in(dat[6:5]), .sync_dir_in(dat[7]), .win_thr_in(dat[9:8]),
		.ilim_in(dat[7:0]), .target_in(dat));
	vbsc_host i_vbsc_host (.*);
	initial begin
		core_clk = 0;
		forever #5 core_clk = ~core_clk;
	end
	task chk(input [31:0] g, input [31:0] e);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task end_of_test;
		if (errors == 0 && cmp_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task clr;
		@(negedge core_clk) flag_clr = 1;
		@(negedge core_clk) flag_clr = 0;
	endtask
	// Comparator flags are sticky until cleared
	task t_ldo;
		@(negedge core_clk) {ldo_below_cmp, ldo_above_cmp} = 2'h3;
		repeat (5) @(negedge core_clk);
		{ldo_below_cmp, ldo_above_cmp} = 2'h0;
		repeat (4) @(negedge core_clk);
		chk({ldo3v3_under_flag, ldo3v3_over_flag}, 2'h3);
		clr;
		chk({ldo3v3_under_flag, ldo3v3_over_flag}, 2'h0);
	endtask
	// Every code of each setting field, except sync_dir which is only written as 0
	task t_cfg;
		for (i = 0; i < 8; i++) begin
			i_vbsc_host.wr(0, {i[1:0], 1'b0, i[1:0], i[1:0], i[2:0]});
			chk({bus_window_thresholds, sync_dir, spread_sel, switch_freq_sel,
				slope_ramp_sel}, {i[1:0], 1'b0, i[1:0], i[1:0], i[2:0]});
		end
		i_vbsc_host.wr(1, 12'h028);
		chk(ilim_sel, 8'h28);
	endtask
	// Refused commands while off
	task t_err;
		i_vbsc_host.wr(3, 12'h077);
		chk({i2c_err_flag, state_out}, 5'h11);
		clr;
		i_vbsc_host.wr(3, 12'h088);
		chk({i2c_err_flag, conv_on, state_out}, 6'h21);
		clr;
	endtask
	// Ramp, custom targets, limit change, back and off
	task t_src;
		output_discharged_in = 1;
		repeat (3) @(negedge core_clk);
		chk(output_discharged_flag, 1'b1);
		i_vbsc_host.src_def;
		chk({conv_on, ramping, state_out}, 6'h32);
		i_vbsc_host.wr(3, 12'h088);
		for (i = 0; i < 100 && ramping === 1'b1; i++) @(negedge core_clk);
		chk(i, SS - 2);
		chk({i2c_err_flag, state_out}, 5'h14);
		clr;
		i_vbsc_host.custom(12'h1F4);
		chk({use_custom, state_out, custom_voltage_target}, 17'h181F4);
		i_vbsc_host.custom(12'h3E8);
		chk({use_custom, state_out, custom_voltage_target}, 17'h183E8);
		i_vbsc_host.wr(1, 12'h0C8);
		chk({ilim_sel, state_out}, 12'hC88);
		i_vbsc_host.wr(3, 12'h077);
		chk({use_custom, ramping, state_out}, 6'h04);
		i_vbsc_host.wr(3, 12'h066);
		chk({conv_on, state_out}, 5'h01);
	endtask
	initial begin
		{nrst, hv_enable_in, ldo_below_cmp, ldo_above_cmp} = 4'h0;
		{output_discharged_in, flag_clr} = 2'h0;
		repeat (6) @(negedge core_clk);
		nrst = 1;
		@(negedge core_clk);
		chk({alert_n, sync_dir, switch_freq_sel, bus_window_thresholds,
			slope_ramp_sel, state_out}, 13'h1C01);
		hv_enable_in = 1;
		for (i = 0; i < 20 && alert_n !== 1'b0; i++) @(negedge core_clk);
		chk(alert_n, 1'b0);
		t_ldo;
		t_cfg;
		t_err;
		t_src;
		end_of_test;
	end
	initial begin
		repeat (3000) @(posedge core_clk);
		errors++;
		end_of_test;
	end
endmodule // test_vbus_source_command_control

// file: tb/vbsc_ctrl_assertions.sv
module vbsc_chk #(
	parameter int SS_CYC = 20
) (
	input wire       core_clk,
	input wire       nrst,
	input wire       hv_enable_in,
	input wire       ldo_below_cmp,
	input wire       cmd_wr,
	input wire [7:0] cmd_code,
	input wire       alert_n,
	input wire       ldo3v3_under_flag,
	input wire       i2c_err_flag,
	input wire       output_discharged_flag,
	input wire       conv_on,
	input wire       ramping,
	input wire [3:0] state_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	wire acc = cmd_wr && !alert_n;        // Command taken
	wire c77 = acc && cmd_code == 8'h77;
	wire c88 = acc && cmd_code == 8'h88;
	wire off = state_out == 4'h1;
	property p_def;
		c77 && off && output_discharged_flag |=> conv_on && state_out == 4'h2;
	endproperty
	a_def: assert property (p_def) else $error("no ramp start");
	property p_err;
		c77 && off && !output_discharged_flag |=> i2c_err_flag && off;
	endproperty
	a_err: assert property (p_err) else $error("no error");
	property p_ndef;
		c88 && state_out == 4'h4 |=> state_out == 4'h8;
	endproperty
	a_ndef: assert property (p_ndef) else $error("no custom");
	property p_nerr;
		c88 && state_out[1:0] != 2'h0 |=> i2c_err_flag && !state_out[3];
	endproperty
	a_nerr: assert property (p_nerr) else $error("custom from off");
	property p_dis;
		acc && cmd_code == 8'h66 |=> !conv_on && off;
	endproperty
	a_dis: assert property (p_dis) else $error("still on");
	// Helper count of consecutive ramping cycles
	int ramp_len;
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst)
			ramp_len <= 0;
		else if (ramping)
			ramp_len <= ramp_len + 1;
		else
			ramp_len <= 0;
	end
	property p_ramp;
		ramping |-> ramp_len < SS_CYC;
	endproperty
	a_ramp: assert property (p_ramp) else $error("ramp too long");
	property p_rend;
		$fell(ramping) && state_out == 4'h4 |-> ramp_len == SS_CYC;
	endproperty
	a_rend: assert property (p_rend) else $error("ramp length");
	property p_uv;
		ldo_below_cmp [*5] |-> ldo3v3_under_flag;
	endproperty
	a_uv: assert property (p_uv) else $error("no under flag");
	property p_pwr;
		hv_enable_in [*5] |-> !alert_n;
	endproperty
	a_pwr: assert property (p_pwr) else $error("no power-up");
	c_cus: cover property (state_out == 4'h8);
	c_err: cover property ($rose(i2c_err_flag));
	c_rmp: cover property ($fell(ramping));
endmodule // vbsc_chk

bind vbsc_ctrl vbsc_chk #(.SS_CYC(SS_CYC)) i_vbsc_chk (.*);

// file: tb/vbsc_host_model.sv
module vbsc_host (
	input  wire        core_clk,
	input  wire        alert_n,
	input  wire        output_discharged_flag,
	output reg  [3:0]  stb,
	output reg  [11:0] dat
);
	timeunit 1ns;
	timeprecision 1ps;
	initial stb = 4'h0;
	initial dat = 12'hAAA;
	// One write: strobe 0 cfg, 1 ilim, 2 target, 3 command
	task wr(input int k, input [11:0] d);
		wait (alert_n === 1'b0);
		@(negedge core_clk);
		stb = 4'h1 << k;
		dat = d;
		@(negedge core_clk);
		stb = 4'h0;
		dat = ~d;                        // Released bus flips
	endtask
	// Default source only if the output already reads discharged; nothing is sent otherwise
	task src_def;
		if (output_discharged_flag === 1'b1) wr(3, 12'h077);
	endtask
	// Target first, then the custom command
	task custom(input [11:0] t);
		wr(2, t);
		wr(3, 12'h088);
	endtask
endmodule // vbsc_host
